// ===== bench/bew_agent_model.sv
// Bus agent model that reports error causes to the bridge as pulses
module bew_agent_model (
    // Clock
    input wire logic clk,
    // Cause pulses toward the bridge
    output logic [7:0] err_event
);
    timeunit 1ns;
    timeprecision 1ps;

    // Causes stay quiet until an agent reports one
    initial begin
        err_event = 8'h00;
    end

    // One-cycle cause pulse; a held level would re-set a cleared bit
    task automatic raise(input logic [7:0] mask);
        @(negedge clk);
        err_event = mask;
        @(negedge clk);
        err_event = 8'h00;
    endtask : raise
endmodule : bew_agent_model

// ===== bench/bew_bridge_cfg_tb.sv
// Self-checking testbench for the bridge status and window decode block
module bew_bridge_cfg_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic cfg_wr = 1'b0;
    logic cfg_rd = 1'b0;
    logic [7:0] cfg_addr = 8'h00;
    logic [3:0] cfg_be = 4'h0;
    logic [31:0] cfg_wdata = 32'h0000_0000;
    logic [31:0] cfg_rdata;
    logic cfg_rvalid;
    logic [7:0] err_event;
    logic [bew_pkg::CTL_BITS-1:0] serr_enable = '0;
    logic master_retry_en = 1'b0;
    logic sec_neg_decode_en = 1'b1;
    logic [31:0] dec_addr = 32'h0000_0000;
    logic dec_io = 1'b0;
    logic pri_claim;
    logic sec_claim;
    logic [7:0] system_error_cause_status;
    logic [1:0] win_enable;
    logic [31:0] e;
    int errors = 0;
    int checks_done = 0;

    // Clock at 250 MHz
    always #2 clk = ~clk;

    bew_bridge_cfg uut (
        .clk(clk), .nrst(nrst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
        .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
        .err_event(err_event), .serr_enable(serr_enable),
        .master_retry_en(master_retry_en),
        .sec_neg_decode_en(sec_neg_decode_en), .dec_addr(dec_addr),
        .dec_io(dec_io), .pri_claim(pri_claim), .sec_claim(sec_claim),
        .system_error_cause_status(system_error_cause_status), .win_enable(win_enable)
    );

    bew_agent_model model (
        .clk(clk),
        .err_event(err_event)
    );

    task automatic give_verdict();
        if (errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input string what, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Write strobe stands for exactly one rising edge
    task automatic wr(input logic [7:0] a, input logic [3:0] be,
                      input logic [31:0] d);
        @(negedge clk);
        cfg_wr = 1'b1;
        cfg_addr = a;
        cfg_be = be;
        cfg_wdata = d;
        @(negedge clk);
        cfg_wr = 1'b0;
    endtask : wr

    // Read answer stands only in the cycle after the strobe
    task automatic rd(input string what, input logic [7:0] a,
                      input logic [31:0] exp);
        @(negedge clk);
        cfg_rd = 1'b1;
        cfg_addr = a;
        @(negedge clk);
        cfg_rd = 1'b0;
        chk({what, " valid"}, {31'h0, cfg_rvalid}, 32'h1);
        chk(what, cfg_rdata, exp);
    endtask : rd

    // Decode result is registered one cycle behind the address
    task automatic dec(input string what, input logic [31:0] a,
                       input logic io, ep, es);
        @(negedge clk);
        dec_addr = a;
        dec_io = io;
        @(negedge clk);
        chk({what, " pri"}, {31'h0, pri_claim}, {31'h0, ep});
        chk({what, " sec"}, {31'h0, sec_claim}, {31'h0, es});
    endtask : dec

    // Watchdog: the whole sequence needs well under 2000 cycles
    initial begin
        #20000;
        errors++;
        give_verdict();
    end

    // Main sequence
    initial begin
        repeat (4) @(negedge clk);
        nrst = 1'b1;
        chk("status reset", {24'h0, system_error_cause_status}, 32'h0);
        rd("status reg", 8'h60, 32'h0);
        rd("window regs", 8'h64, 32'h0);
        rd("unmapped", 8'h00, 32'h0);
        wr(8'h64, 4'hF, 32'hFFFF_FFFF);
        rd("window regs", 8'h64, 32'h0000_0303);
        chk("window enable", {30'h0, win_enable}, 32'h3);
        // Every cause with its gate open accumulates in order
        serr_enable = '1;
        master_retry_en = 1'b1;
        for (int n = 0; n < 8; n++) begin
            model.raise(8'h01 << n);
            e = (32'h2 << n) - 32'h1;
            chk("set", {24'h0, system_error_cause_status}, e);
        end
        wr(8'h60, 4'h2, 32'h0000_0000);
        wr(8'h60, 4'h1, 32'hFFFF_FFFF);
        rd("status hold", 8'h60, 32'h0000_FF00);
        wr(8'h60, 4'h2, 32'h0000_A500);
        rd("status w1c", 8'h60, 32'h0000_5A00);
        wr(8'h60, 4'h2, 32'h0000_FF00);
        // Closed gates drop the cause; the address parity cause has none
        serr_enable = '0;
        master_retry_en = 1'b0;
        model.raise(8'hBF);
        chk("ungated", {24'h0, system_error_cause_status}, 32'h0);
        model.raise(8'h40);
        chk("addr parity", {24'h0, system_error_cause_status}, 32'h40);
        // A cause coinciding with its own clear keeps the bit
        fork
            wr(8'h60, 4'h2, 32'h0000_FF00);
            model.raise(8'h40);
        join
        chk("set beats clear", {24'h0, system_error_cause_status}, 32'h40);
        // Window 0: one 4K memory page
        wr(8'h44, 4'hF, 32'h0000_1000);
        wr(8'h48, 4'hF, 32'h0000_1000);
        wr(8'h64, 4'h3, 32'h0000_0001);
        dec("w0 in", 32'h0000_1ABC, 1'b0, 1'b1, 1'b0);
        dec("w0 above", 32'h0000_2000, 1'b0, 1'b0, 1'b1);
        dec("w0 io", 32'h0000_1ABC, 1'b1, 1'b0, 1'b1);
        wr(8'h64, 4'h3, 32'h0000_0101);
        rd("map", 8'h64, 32'h0000_0101);
        dec("w0 excl", 32'h0000_1ABC, 1'b0, 1'b0, 1'b1);
        sec_neg_decode_en = 1'b0;
        dec("w0 pos", 32'h0000_1ABC, 1'b0, 1'b0, 1'b1);
        dec("outside", 32'h0000_2000, 1'b0, 1'b0, 1'b0);
        // Window 1: I/O range with double-word granularity
        wr(8'h4C, 4'hF, 32'h0000_0303);
        rd("base1", 8'h4C, 32'h0000_0300);
        wr(8'h50, 4'hF, 32'h0000_0302);
        wr(8'h64, 4'h3, 32'h0000_0103);
        dec("w1 io", 32'h0000_0303, 1'b1, 1'b1, 1'b0);
        dec("w1 mem", 32'h0000_0303, 1'b0, 1'b0, 1'b0);
        wr(8'h64, 4'h3, 32'h0000_0100);
        dec("off", 32'h0000_1ABC, 1'b0, 1'b0, 1'b0);
        // Second reset in mid-run clears everything again
        @(negedge clk);
        nrst = 1'b0;
        @(negedge clk);
        nrst = 1'b1;
        rd("status rst2", 8'h60, 32'h0);
        rd("window rst2", 8'h64, 32'h0);
        give_verdict();
    end
endmodule : bew_bridge_cfg_tb

// ===== design/bew_bridge_cfg.sv
// System-error cause status and extension window decode for the bridge
// Function
// - 8-bit error cause status at 61h, cleared on reset.
// - Bit 7 records master timeout, also gated by master retry enable.
// - Bit 6 records address parity error system errors.
// - Bit 5 records data parity error while the bridge mastered.
// - Bit 4 records discard timer expiry on nonprefetchable reads.
// - Bit 3 records master abort on posted writes.
// - Bit 2 records target abort on posted writes.
// - Bit 1 records parity error on posted writes.
// - Bit 0 records arbiter timer expiry.
// - Status bits are sticky; writing one clears, zero leaves them.
// - Causes 5..0 are recorded only while their control enable is set.
// - Window enable register at 64h, resets zero, bits 7:2 read zero.
// - Enable bits 1 and 0 switch decode of windows 1 and 0.
// - Window map register at 65h, resets zero, two low bits writable.
// - Map bit zero includes window in primary decode, one excludes.
// - With secondary negative decode, secondary decode is the inverse of primary decode.
// - Without secondary negative decode, excluded windows decode positively.
// - Each window has 32-bit base and limit; limit low bits give type.
// - Memory windows 4K granular, I/O windows double-word granular.
// - Window definitions only act while the window enable is set.
module bew_bridge_cfg #(
    parameter int AW = 32
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Configuration access from the primary bus
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    output logic [31:0] cfg_rdata,
    output logic cfg_rvalid,
    // Error causes and their reporting enables
    input wire logic [7:0] err_event,
    input wire logic [bew_pkg::CTL_BITS-1:0] serr_enable,
    input wire logic master_retry_en,
    // Secondary decode control input
    input wire logic sec_neg_decode_en,
    // Transaction under decode
    input wire logic [AW-1:0] dec_addr,
    input wire logic dec_io,
    // Decode results and register views
    output logic pri_claim,
    output logic sec_claim,
    output logic [7:0] system_error_cause_status,
    output logic [1:0] win_enable
);
    bew_pkg::bew_state_t q;
    bew_pkg::bew_state_t d;
    logic [bew_pkg::NUM_WIN-1:0] win_hit;
    logic [7:0] cause_set;
    logic [5:0] dw_addr;
    logic [31:0] rd_word;
    logic inc_hit;
    logic exc_hit;

    // Merge written bytes into an old word under the byte enables
    function automatic logic [31:0] be_merge(
        input logic [31:0] old,
        input logic [31:0] wdata,
        input logic [3:0] be
    );
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[8*i +: 8] = wdata[8*i +: 8];
            end
        end
        return res;
    endfunction : be_merge

    // One comparator per window
    for (genvar w = 0; w < bew_pkg::NUM_WIN; w++) begin : g_win
        bew_window_match #(
            .AW(AW)
        ) u_match (
            .enable(q.win_en[w]),
            .base(q.base[w][AW-1:0]),
            .limit(q.limit[w][AW-1:0]),
            .addr(dec_addr),
            .io_cycle(dec_io),
            .hit(win_hit[w])
        );
    end

    // Causes that are allowed to latch this cycle
    always_comb begin
        cause_set = 8'h00;
        cause_set[bew_pkg::ST_MASTER_TMO] =
            err_event[bew_pkg::ST_MASTER_TMO] && master_retry_en;
        // Address parity has no separate enable here
        cause_set[bew_pkg::ST_ADDR_PAR] =
            err_event[bew_pkg::ST_ADDR_PAR];
        // Causes 5..0 each gated by its own enable
        cause_set[bew_pkg::CTL_BITS-1:0] =
            err_event[bew_pkg::CTL_BITS-1:0] & serr_enable;
    end

    // Split windows by primary include or exclude
    always_comb begin
        inc_hit = |(win_hit & ~q.win_map);
        exc_hit = |(win_hit & q.win_map);
    end

    // Configuration read mux; unmapped dwords and reserved bits read zero
    always_comb begin
        dw_addr = cfg_addr[7:2];
        rd_word = 32'h0000_0000;
        if (dw_addr == bew_pkg::OFF_STATUS[7:2]) begin
            rd_word[8*bew_pkg::OFF_STATUS[1:0] +: 8] = q.status;
        end else if (dw_addr == bew_pkg::OFF_WIN_EN[7:2]) begin
            rd_word[8*bew_pkg::OFF_WIN_EN[1:0] +: 2] = q.win_en;
            rd_word[8*bew_pkg::OFF_WIN_MAP[1:0] +: 2] = q.win_map;
        end else if (dw_addr == bew_pkg::OFF_BASE0[7:2]) begin
            rd_word = q.base[0];
        end else if (dw_addr == bew_pkg::OFF_LIMIT0[7:2]) begin
            rd_word = q.limit[0];
        end else if (dw_addr == bew_pkg::OFF_BASE1[7:2]) begin
            rd_word = q.base[1];
        end else if (dw_addr == bew_pkg::OFF_LIMIT1[7:2]) begin
            rd_word = q.limit[1];
        end
    end

    // Next state
    always_comb begin
        d = q;
        d.rvalid = cfg_rd;
        d.rdata = cfg_rd ? rd_word : 32'h0000_0000;
        // Sticky status: a new cause wins over a clear in the same cycle
        d.status = q.status | cause_set;
        if (cfg_wr) begin
            if (dw_addr == bew_pkg::OFF_STATUS[7:2]) begin
                if (cfg_be[bew_pkg::OFF_STATUS[1:0]]) begin
                    d.status = (q.status
                        & ~cfg_wdata[8*bew_pkg::OFF_STATUS[1:0] +: 8])
                        | cause_set;
                end
            end else if (dw_addr == bew_pkg::OFF_WIN_EN[7:2]) begin
                if (cfg_be[bew_pkg::OFF_WIN_EN[1:0]]) begin
                    d.win_en =
                        cfg_wdata[8*bew_pkg::OFF_WIN_EN[1:0] +: 2];
                end
                if (cfg_be[bew_pkg::OFF_WIN_MAP[1:0]]) begin
                    d.win_map =
                        cfg_wdata[8*bew_pkg::OFF_WIN_MAP[1:0] +: 2];
                end
            end else if (dw_addr == bew_pkg::OFF_BASE0[7:2]) begin
                d.base[0] = be_merge(q.base[0], cfg_wdata, cfg_be)
                            & bew_pkg::BASE_WR_MASK;
            end else if (dw_addr == bew_pkg::OFF_LIMIT0[7:2]) begin
                d.limit[0] = be_merge(q.limit[0], cfg_wdata, cfg_be);
            end else if (dw_addr == bew_pkg::OFF_BASE1[7:2]) begin
                d.base[1] = be_merge(q.base[1], cfg_wdata, cfg_be)
                            & bew_pkg::BASE_WR_MASK;
            end else if (dw_addr == bew_pkg::OFF_LIMIT1[7:2]) begin
                d.limit[1] = be_merge(q.limit[1], cfg_wdata, cfg_be);
            end
        end
        // Primary claims included windows only
        d.pri_claim = inc_hit;
        // Secondary: negative decode forwards all that primary does not
        // claim; otherwise only excluded windows decode positively
        if (sec_neg_decode_en) begin
            d.sec_claim = !inc_hit;
        end else begin
            d.sec_claim = exc_hit;
        end
    end

    // State register; status and windows start cleared
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q <= bew_pkg::RST_STATE;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state register
    assign cfg_rdata = q.rdata;
    assign cfg_rvalid = q.rvalid;
    assign pri_claim = q.pri_claim;
    assign sec_claim = q.sec_claim;
    assign system_error_cause_status = q.status;
    assign win_enable = q.win_en;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    // Master timeout latches only with retry enable
    chk_master_tmo_set: assert property (
        err_event[7] && master_retry_en |=> system_error_cause_status[7])
        else $error("master timeout not recorded");

    // Without retry enable a master timeout must not latch
    chk_master_tmo_gate: assert property (
        !master_retry_en && !system_error_cause_status[7] |=> !system_error_cause_status[7])
        else $error("status bit 7 set without retry enable");

    chk_addr_par_set: assert property (
        err_event[6] |=> system_error_cause_status[6])
        else $error("address parity cause not recorded");

    chk_gated_set: assert property (
        (err_event[5:0] & serr_enable) != 6'h00
        |=> (system_error_cause_status[5:0] & $past(err_event[5:0] & serr_enable))
            == $past(err_event[5:0] & serr_enable))
        else $error("enabled cause not recorded");

    chk_disabled_cause: assert property (
        !serr_enable[0] && !system_error_cause_status[0] |=> !system_error_cause_status[0])
        else $error("disabled cause recorded");

    chk_w1c_clear: assert property (
        cfg_wr && cfg_addr[7:2] == 6'h18 && cfg_be[1] && cfg_wdata[8]
        && !(err_event[0] && serr_enable[0]) |=> !system_error_cause_status[0])
        else $error("write one did not clear status");

    chk_status_hold: assert property (
        system_error_cause_status[3] && !(cfg_wr && cfg_addr[7:2] == 6'h18)
        |=> system_error_cause_status[3] [*1])
        else $error("status bit dropped without clear");

    chk_reserved_zero: assert property (
        cfg_rd && cfg_addr[7:2] == 6'h19
        |=> cfg_rvalid && cfg_rdata[7:2] == 6'h00
            && cfg_rdata[15:10] == 6'h00)
        else $error("reserved window bits not zero");

    chk_sec_inverse: assert property (
        sec_neg_decode_en |=> sec_claim != pri_claim)
        else $error("secondary not inverse of primary");

    chk_win_off: assert property (
        win_enable == 2'h0 && !sec_neg_decode_en
        |=> !pri_claim && !sec_claim)
        else $error("disabled windows claimed");

    // Read answer comes exactly one cycle after the strobe
    chk_rd_latency: assert property (
        cfg_rd |=> cfg_rvalid)
        else $error("read answer missing");

    // Idle cycles keep the answer low so stale data never shows
    chk_rd_idle: assert property (
        !cfg_rd |=> !cfg_rvalid && cfg_rdata == 32'h0000_0000)
        else $error("read answer outside read cycle");

    // Status read shows the register in lane 1 only
    chk_status_read: assert property (
        cfg_rd && cfg_addr[7:2] == 6'h18
        |=> cfg_rdata == {16'h0000, $past(system_error_cause_status), 8'h00})
        else $error("status read wrong");

    // Window registers read back in lanes 0 and 1
    chk_win_read: assert property (
        cfg_rd && cfg_addr[7:2] == 6'h19
        |=> cfg_rdata[1:0] == $past(q.win_en)
            && cfg_rdata[9:8] == $past(q.win_map))
        else $error("window register read wrong");

    // A write never sets a status bit on its own
    chk_wr_no_set: assert property (
        cfg_wr && err_event == 8'h00
        |=> (system_error_cause_status & ~$past(system_error_cause_status)) == 8'h00)
        else $error("write set a status bit");

    // A rising cause bit 5..0 needs its enable in the cycle before
    chk_gate_closed: assert property (
        1'b1 |=> (system_error_cause_status[5:0] & ~$past(system_error_cause_status[5:0])
                  & ~$past(serr_enable)) == 6'h00)
        else $error("cause recorded while disabled");

    // Disabled windows never report a hit
    chk_win_disabled: assert property (
        (win_hit & ~q.win_en) == 2'h0)
        else $error("disabled window hit");

    // Base low bits stay zero whatever is written
    chk_base_low: assert property (
        q.base[0][1:0] == 2'h0 && q.base[1][1:0] == 2'h0)
        else $error("base low bits not zero");

    // Included hit claims on the primary, no included hit drops it
    chk_pri_include: assert property (
        (win_hit & ~q.win_map) != 2'h0 |=> pri_claim)
        else $error("included window not claimed");

    chk_pri_exclude: assert property (
        (win_hit & ~q.win_map) == 2'h0 |=> !pri_claim)
        else $error("primary claim without included hit");

    // Excluded hit decodes positively without negative decode
    chk_sec_positive: assert property (
        !sec_neg_decode_en && (win_hit & q.win_map) != 2'h0
        |=> sec_claim)
        else $error("excluded window not claimed on secondary");
endmodule : bew_bridge_cfg

// ===== design/bew_window_match.sv
// One extension window range and type comparator
module bew_window_match #(
    parameter int AW = 32
) (
    // Window definition
    input wire logic enable,
    input wire logic [AW-1:0] base,
    input wire logic [AW-1:0] limit,
    // Transaction under decode
    input wire logic [AW-1:0] addr,
    input wire logic io_cycle,
    // Result
    output logic hit
);
    logic io_win;
    logic [AW-1:0] gran;
    logic [AW-1:0] lo;
    logic [AW-1:0] hi;

    // Window type and granularity come from the limit type field
    always_comb begin
        io_win = limit[bew_pkg::LIM_IO_BIT];
        gran = io_win ? bew_pkg::IO_GRAN_MASK[AW-1:0]
                      : bew_pkg::MEM_GRAN_MASK[AW-1:0];
        lo = base & ~gran;
        hi = limit | gran;
        // Inclusive range and matching space, only while enabled
        hit = enable && (addr >= lo) && (addr <= hi)
              && (io_cycle == io_win);
    end
endmodule : bew_window_match

// ===== include/bew_pkg.sv
// Package: offsets, field positions, reset values and types for the bridge
package bew_pkg;
    // Configuration byte offsets
    localparam logic [7:0] OFF_STATUS = 8'h61;
    localparam logic [7:0] OFF_WIN_EN = 8'h64;
    localparam logic [7:0] OFF_WIN_MAP = 8'h65;
    localparam logic [7:0] OFF_BASE0 = 8'h44;
    localparam logic [7:0] OFF_LIMIT0 = 8'h48;
    localparam logic [7:0] OFF_BASE1 = 8'h4C;
    localparam logic [7:0] OFF_LIMIT1 = 8'h50;

    // Status bit positions
    localparam int ST_MASTER_TMO = 7;
    localparam int ST_ADDR_PAR = 6;
    localparam int ST_DATA_PAR = 5;
    localparam int ST_DISCARD = 4;
    localparam int ST_PW_MABORT = 3;
    localparam int ST_PW_TABORT = 2;
    localparam int ST_PW_PARITY = 1;
    localparam int ST_ARB_TMO = 0;

    // Number of status causes gated by the system-error control enables
    localparam int CTL_BITS = 6;
    // Number of extension windows
    localparam int NUM_WIN = 2;

    // Limit register type field: bit 1 set selects I/O space
    localparam int LIM_IO_BIT = 1;
    // Granularity masks: 4K-byte memory, double-word I/O
    localparam logic [31:0] MEM_GRAN_MASK = 32'h0000_0FFF;
    localparam logic [31:0] IO_GRAN_MASK = 32'h0000_0003;
    // Base register bits 1:0 are read-only zero
    localparam logic [31:0] BASE_WR_MASK = 32'hFFFF_FFFC;

    // Reset values
    localparam logic [7:0] RST_STATUS = 8'h00;
    localparam logic [1:0] RST_WIN_EN = 2'h0;
    localparam logic [1:0] RST_WIN_MAP = 2'h0;
    localparam logic [31:0] RST_BASE = 32'h0000_0000;
    localparam logic [31:0] RST_LIMIT = 32'h0000_0000;

    // Whole register state of the block
    typedef struct packed {
        logic [7:0] status;
        logic [1:0] win_en;
        logic [1:0] win_map;
        logic [NUM_WIN-1:0][31:0] base;
        logic [NUM_WIN-1:0][31:0] limit;
        logic [31:0] rdata;
        logic rvalid;
        logic pri_claim;
        logic sec_claim;
    } bew_state_t;

    localparam bew_state_t RST_STATE = '{
        status: RST_STATUS,
        win_en: RST_WIN_EN,
        win_map: RST_WIN_MAP,
        base: {NUM_WIN{RST_BASE}},
        limit: {NUM_WIN{RST_LIMIT}},
        rdata: 32'h0000_0000,
        rvalid: 1'b0,
        pri_claim: 1'b0,
        sec_claim: 1'b0
    };
endpackage : bew_pkg
